// ---- inc/bias_cfg_pkg.sv ----
// alarm-threshold and hardware/software configuration bank: constants and carriers
// assumes a host drives the command-byte serial link; one 25 MHz clock samples it
package bias_cfg_pkg;

    localparam logic [7:0] READ_FLAG          = 8'h80;
    localparam logic [6:0] CMD_CH1_HIGH_SENSE = 7'h24;
    localparam logic [6:0] CMD_CH1_LOW_SENSE  = 7'h26;
    localparam logic [6:0] CMD_CH1_HIGH_GATE  = 7'h28;
    localparam logic [6:0] CMD_CH1_LOW_GATE   = 7'h2A;
    localparam logic [6:0] CMD_CH2_HIGH_SENSE = 7'h30;
    localparam logic [6:0] CMD_CH2_LOW_SENSE  = 7'h32;
    localparam logic [6:0] CMD_CH2_HIGH_GATE  = 7'h34;
    localparam logic [6:0] CMD_CH2_LOW_GATE   = 7'h36;
    localparam logic [6:0] CMD_HW_CONFIG      = 7'h38;
    localparam logic [6:0] CMD_SW_CONFIG      = 7'h3A;

    // slot numbers inside the bank
    localparam logic [3:0] SLOT_CH1_HIGH_SENSE = 4'h0;
    localparam logic [3:0] SLOT_CH1_LOW_SENSE  = 4'h1;
    localparam logic [3:0] SLOT_CH1_HIGH_GATE  = 4'h2;
    localparam logic [3:0] SLOT_CH1_LOW_GATE   = 4'h3;
    localparam logic [3:0] SLOT_CH2_HIGH_SENSE = 4'h4;
    localparam logic [3:0] SLOT_CH2_LOW_SENSE  = 4'h5;
    localparam logic [3:0] SLOT_CH2_HIGH_GATE  = 4'h6;
    localparam logic [3:0] SLOT_CH2_LOW_GATE   = 4'h7;
    localparam logic [3:0] SLOT_HW_CONFIG      = 4'h8;
    localparam logic [3:0] SLOT_SW_CONFIG      = 4'h9;

    // frame layout: command byte then sixteen data bits, msb first
    localparam logic [4:0] CMD_LAST_BIT   = 5'h07;
    localparam logic [4:0] FRAME_LAST_BIT = 5'h17;
    localparam logic [4:0] FRAME_BITS     = 5'h18;

    localparam logic [11:0] RESET_HIGH_THRESHOLD = 12'hFFF;
    localparam logic [11:0] RESET_LOW_THRESHOLD  = 12'h000;
    localparam logic [11:0] RESET_CONFIG         = 12'h000;

    localparam logic [1:0] CLOCK_MODE_WRITE   = 2'h0;
    localparam logic [1:0] CLOCK_MODE_PULSE   = 2'h1;
    localparam logic [1:0] CLOCK_MODE_RESERVED = 2'h2;
    localparam logic [1:0] CLOCK_MODE_PER_CH  = 2'h3;

    // field order mirrors slot order, slot 7 in the msbs
    typedef struct packed {
        logic [11:0] ch2_low_gate_threshold;
        logic [11:0] ch2_high_gate_threshold;
        logic [11:0] ch2_low_sense_threshold;
        logic [11:0] ch2_high_sense_threshold;
        logic [11:0] ch1_low_gate_threshold;
        logic [11:0] ch1_high_gate_threshold;
        logic [11:0] ch1_low_sense_threshold;
        logic [11:0] ch1_high_sense_threshold;
    } thresholds_s;

    typedef struct packed {
        logic ch2_gate_ceiling_hi;
        logic ch2_gate_ceiling_lo;
        logic ch1_gate_ceiling_hi;
        logic ch1_gate_ceiling_lo;
        logic fifo_monitor_enable;
        logic clock_mode_hi;
        logic clock_mode_lo;
        logic adc_ref_select_hi;
        logic adc_ref_select_lo;
        logic dac_ref_select_hi;
        logic dac_ref_select_lo;
    } hw_config_s;

    typedef struct packed {
        logic       ch2_load_dac_output;
        logic [1:0] ch2_temp_lookup_mode;
        logic [2:0] ch2_k_source;
        logic       ch1_load_dac_output;
        logic [1:0] ch1_temp_lookup_mode;
        logic [2:0] ch1_k_source;
    } sw_config_s;

endpackage

// ---- verilog/bias_cfg_regs.sv ----
// alarm-threshold and configuration register bank behind the command-byte serial port
// assumes the serial pins are asynchronous and slow against clk_in (sclk <= ~3 MHz)
`timescale 1ns/10ps
module bias_cfg_regs
(
    // clock, reset, enable
    input  wire logic                      clk_in,
    input  wire logic                      nrst_in,
    input  wire logic                      ce_in,
    // serial command port
    input  wire logic                      serial_clock_in,
    input  wire logic                      serial_select_n_in,
    input  wire logic                      serial_data_in,
    output logic                           serial_data_out,
    output logic                           serial_data_oe_out,
    // conversion start
    input  wire logic                      conversion_start_pin_n_in,
    input  wire logic                      conversion_write_in,
    output logic                           conversion_start_out,
    output logic                           conversion_per_channel_out,
    // adc result routing
    input  wire logic                      adc_result_valid_in,
    output logic                           fifo_push_out,
    output logic                           alarm_check_out,
    // configuration to the analog and dac logic
    output bias_cfg_pkg::thresholds_s      thresholds_out,
    output bias_cfg_pkg::hw_config_s       hw_config_out,
    output bias_cfg_pkg::sw_config_s       sw_config_out
);

    typedef struct packed {
        logic [1:0]       cs_sync;
        logic [1:0]       sclk_sync;
        logic [1:0]       din_sync;
        logic [1:0]       start_sync;
        logic             sclk_prev;
        logic             start_prev;
        logic [4:0]       bit_cnt;
        logic [7:0]       cmd;
        logic [15:0]      data_sh;
        logic             rd_active;
        logic             dout;
        logic             dout_oe;
        logic [7:0][11:0] thr;
        logic [11:0]      hw_word;
        logic [11:0]      sw_word;
        logic             fifo_push;
        logic             alarm_check;
        logic             conv_start;
        logic             conv_per_channel;
    } state_s;

    state_s s;
    state_s next_s;

    // msb of the result flags a mapped code, low nibble is the slot
    function automatic logic [4:0] slot_of(input logic [6:0] code);
        logic [4:0] r;
        r = 5'h00;
        if (code == bias_cfg_pkg::CMD_CH1_HIGH_SENSE)
            r = {1'b1, bias_cfg_pkg::SLOT_CH1_HIGH_SENSE};
        else if (code == bias_cfg_pkg::CMD_CH1_LOW_SENSE)
            r = {1'b1, bias_cfg_pkg::SLOT_CH1_LOW_SENSE};
        else if (code == bias_cfg_pkg::CMD_CH1_HIGH_GATE)
            r = {1'b1, bias_cfg_pkg::SLOT_CH1_HIGH_GATE};
        else if (code == bias_cfg_pkg::CMD_CH1_LOW_GATE)
            r = {1'b1, bias_cfg_pkg::SLOT_CH1_LOW_GATE};
        else if (code == bias_cfg_pkg::CMD_CH2_HIGH_SENSE)
            r = {1'b1, bias_cfg_pkg::SLOT_CH2_HIGH_SENSE};
        else if (code == bias_cfg_pkg::CMD_CH2_LOW_SENSE)
            r = {1'b1, bias_cfg_pkg::SLOT_CH2_LOW_SENSE};
        else if (code == bias_cfg_pkg::CMD_CH2_HIGH_GATE)
            r = {1'b1, bias_cfg_pkg::SLOT_CH2_HIGH_GATE};
        else if (code == bias_cfg_pkg::CMD_CH2_LOW_GATE)
            r = {1'b1, bias_cfg_pkg::SLOT_CH2_LOW_GATE};
        else if (code == bias_cfg_pkg::CMD_HW_CONFIG)
            r = {1'b1, bias_cfg_pkg::SLOT_HW_CONFIG};
        else if (code == bias_cfg_pkg::CMD_SW_CONFIG)
            r = {1'b1, bias_cfg_pkg::SLOT_SW_CONFIG};
        return r;
    endfunction

    logic        sclk_rise;
    logic        sclk_fall;
    logic        start_fall;
    logic        start_rise;
    logic        din;
    logic [7:0]  cmd_full;
    logic [4:0]  slot;
    logic [15:0] rd_word;

    always_comb
    begin
        next_s = s;
        rd_word = 16'h0000;
        // first flop of each synchroniser feeds only the second
        next_s.cs_sync    = {s.cs_sync[0], serial_select_n_in};
        next_s.sclk_sync  = {s.sclk_sync[0], serial_clock_in};
        next_s.din_sync   = {s.din_sync[0], serial_data_in};
        next_s.start_sync = {s.start_sync[0], conversion_start_pin_n_in};
        next_s.sclk_prev  = s.sclk_sync[1];
        next_s.start_prev = s.start_sync[1];
        sclk_rise  = s.sclk_sync[1] & ~s.sclk_prev;
        sclk_fall  = ~s.sclk_sync[1] & s.sclk_prev;
        start_fall = ~s.start_sync[1] & s.start_prev;
        start_rise = s.start_sync[1] & ~s.start_prev;
        din        = s.din_sync[1];
        cmd_full   = {s.cmd[6:0], din};
        slot       = slot_of(s.cmd[6:0]);

        if (s.cs_sync[1])
        begin
            // deselect aborts any partial frame; a short write stores nothing
            next_s.bit_cnt   = 5'h00;
            next_s.rd_active = 1'b0;
            next_s.dout_oe   = 1'b0;
            next_s.dout      = 1'b0;
        end
        else
        begin
            if (sclk_rise && s.bit_cnt != bias_cfg_pkg::FRAME_BITS)
            begin
                next_s.bit_cnt = s.bit_cnt + 5'h01;
                if (s.bit_cnt <= bias_cfg_pkg::CMD_LAST_BIT)
                begin
                    next_s.cmd = cmd_full;
                    if (s.bit_cnt == bias_cfg_pkg::CMD_LAST_BIT && cmd_full[7])
                    begin
                        slot = slot_of(cmd_full[6:0]);
                        // upper nibble and unmapped codes read as zero
                        if (!slot[4])
                            rd_word = 16'h0000;
                        else if (slot[3:0] < bias_cfg_pkg::SLOT_HW_CONFIG)
                            rd_word = {4'h0, s.thr[slot[2:0]]};
                        else if (slot[3:0] == bias_cfg_pkg::SLOT_HW_CONFIG)
                            rd_word = {4'h0, s.hw_word};
                        else
                            rd_word = {4'h0, s.sw_word};
                        next_s.data_sh   = rd_word;
                        next_s.rd_active = 1'b1;
                    end
                end
                else if (!s.rd_active)
                begin
                    next_s.data_sh = {s.data_sh[14:0], din};
                    // store on the last data bit; bits 15..12 dropped
                    if (s.bit_cnt == bias_cfg_pkg::FRAME_LAST_BIT && !s.cmd[7] && slot[4])
                    begin
                        if (slot[3:0] < bias_cfg_pkg::SLOT_HW_CONFIG)
                            next_s.thr[slot[2:0]] = s.data_sh[10:0] == 11'h000 ?
                                {11'h000, din} : {s.data_sh[10:0], din};
                        else if (slot[3:0] == bias_cfg_pkg::SLOT_HW_CONFIG)
                            next_s.hw_word = {s.data_sh[10:0], din};
                        else
                            next_s.sw_word = {s.data_sh[10:0], din};
                    end
                end
            end
            // read data changes on the falling edge, msb first
            if (sclk_fall && s.rd_active)
            begin
                next_s.dout    = s.data_sh[15];
                next_s.data_sh = {s.data_sh[14:0], 1'b0};
                next_s.dout_oe = 1'b1;
            end
        end

        // results always reach the alarm checker; only the fifo sees the monitor bit
        next_s.fifo_push   = adc_result_valid_in & s.hw_word[6];
        next_s.alarm_check = adc_result_valid_in;

        next_s.conv_start       = 1'b0;
        next_s.conv_per_channel = 1'b0;
        case (s.hw_word[5:4])
            bias_cfg_pkg::CLOCK_MODE_WRITE:
                next_s.conv_start = conversion_write_in;
            bias_cfg_pkg::CLOCK_MODE_PULSE:
                next_s.conv_start = start_fall;
            bias_cfg_pkg::CLOCK_MODE_PER_CH:
            begin
                // acquisition runs while low, sample taken on the return high
                next_s.conv_start       = start_rise;
                next_s.conv_per_channel = start_rise;
            end
            default:
                next_s.conv_start = 1'b0;
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
        begin
            s <= '0;
            s.cs_sync    <= 2'h3;
            s.sclk_sync  <= 2'h0;
            s.start_sync <= 2'h3;
            s.start_prev <= 1'b1;
            s.thr[bias_cfg_pkg::SLOT_CH1_HIGH_SENSE[2:0]] <= bias_cfg_pkg::RESET_HIGH_THRESHOLD;
            s.thr[bias_cfg_pkg::SLOT_CH2_HIGH_SENSE[2:0]] <= bias_cfg_pkg::RESET_HIGH_THRESHOLD;
            s.thr[bias_cfg_pkg::SLOT_CH1_LOW_SENSE[2:0]]  <= bias_cfg_pkg::RESET_LOW_THRESHOLD;
            s.thr[bias_cfg_pkg::SLOT_CH2_LOW_SENSE[2:0]]  <= bias_cfg_pkg::RESET_LOW_THRESHOLD;
            s.thr[bias_cfg_pkg::SLOT_CH1_HIGH_GATE[2:0]]  <= bias_cfg_pkg::RESET_HIGH_THRESHOLD;
            s.thr[bias_cfg_pkg::SLOT_CH2_HIGH_GATE[2:0]]  <= bias_cfg_pkg::RESET_HIGH_THRESHOLD;
            s.thr[bias_cfg_pkg::SLOT_CH1_LOW_GATE[2:0]]   <= bias_cfg_pkg::RESET_LOW_THRESHOLD;
            s.thr[bias_cfg_pkg::SLOT_CH2_LOW_GATE[2:0]]   <= bias_cfg_pkg::RESET_LOW_THRESHOLD;
            s.hw_word <= bias_cfg_pkg::RESET_CONFIG;
            s.sw_word <= bias_cfg_pkg::RESET_CONFIG;
        end
        else if (ce_in)
        begin
            s <= next_s;
        end
    end

    // codes leave as stored: unsigned, full scale = quarter of dac reference
    assign thresholds_out = bias_cfg_pkg::thresholds_s'(s.thr);
    // ceiling code 0..3 means agnd + 0/250/500/750 mV; ref hi bit = internal
    assign hw_config_out  = bias_cfg_pkg::hw_config_s'({s.hw_word[11:8], s.hw_word[6:0]});
    assign sw_config_out  = bias_cfg_pkg::sw_config_s'(s.sw_word);
    assign serial_data_out            = s.dout;
    assign serial_data_oe_out         = s.dout_oe;
    assign fifo_push_out              = s.fifo_push;
    assign alarm_check_out            = s.alarm_check;
    assign conversion_start_out       = s.conv_start;
    assign conversion_per_channel_out = s.conv_per_channel;

endmodule

// ---- bench/bias_cfg_regs_props.sv ----
// checker for the threshold and configuration bank
// bound to bias_cfg_regs; sees its ports only
`timescale 1ns/10ps
module bias_cfg_regs_props
(
    // clock, reset and enable
    input wire logic                      clk_in,
    input wire logic                      nrst_in,
    input wire logic                      ce_in,
    // inputs watched
    input wire logic                      serial_select_n_in,
    input wire logic                      conversion_write_in,
    input wire logic                      adc_result_valid_in,
    // outputs watched
    input wire logic                      conversion_start_out,
    input wire logic                      conversion_per_channel_out,
    input wire logic                      fifo_push_out,
    input wire logic                      alarm_check_out,
    input wire bias_cfg_pkg::thresholds_s thresholds_out,
    input wire bias_cfg_pkg::hw_config_s  hw_config_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    property p_alarm;
        ce_in && adc_result_valid_in |=> alarm_check_out;
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm check missing");
    property p_fifo_on;
        ce_in && adc_result_valid_in && hw_config_out.fifo_monitor_enable |=> fifo_push_out;
    endproperty
    a_fifo_on: assert property (p_fifo_on) else $error("fifo push missing");
    property p_fifo_off;
        fifo_push_out |-> $past(hw_config_out.fifo_monitor_enable) && $past(adc_result_valid_in);
    endproperty
    a_fifo_off: assert property (p_fifo_off) else $error("fifo push unasked");
    property p_conv_write;
        ce_in && conversion_write_in && hw_config_out[5:4] == 2'h0 |=> conversion_start_out;
    endproperty
    a_conv_write: assert property (p_conv_write) else $error("write start missing");
    property p_per_ch;
        conversion_per_channel_out |-> conversion_start_out && $past(hw_config_out[5:4]) == 2'h3;
    endproperty
    a_per_ch: assert property (p_per_ch) else $error("per channel pulse wrong");
    property p_reserved;
        $past(hw_config_out[5:4]) == 2'h2 |-> !conversion_start_out;
    endproperty
    a_reserved: assert property (p_reserved) else $error("start in reserved mode");
    // reset acts whatever ce_in does, so no disable here
    property p_reset;
        disable iff (1'b0) !nrst_in |=> hw_config_out == '0 && thresholds_out
            == {4{12'h000, 12'hFFF}};
    endproperty
    a_reset: assert property (p_reset) else $error("reset value wrong");
    property p_hold;
        serial_select_n_in [*5] |-> $stable(thresholds_out) && $stable(hw_config_out);
    endproperty
    a_hold: assert property (p_hold) else $error("register moved outside a frame");
    c_fifo: cover property (fifo_push_out);
    c_per_ch: cover property (conversion_per_channel_out);
    c_alarm_only: cover property (alarm_check_out && !fifo_push_out);
endmodule

bind bias_cfg_regs bias_cfg_regs_props u_props
(
    .clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in),
    .serial_select_n_in(serial_select_n_in), .conversion_write_in(conversion_write_in),
    .adc_result_valid_in(adc_result_valid_in), .conversion_start_out(conversion_start_out),
    .conversion_per_channel_out(conversion_per_channel_out),
    .fifo_push_out(fifo_push_out), .alarm_check_out(alarm_check_out),
    .thresholds_out(thresholds_out), .hw_config_out(hw_config_out)
);

// ---- bench/host_serial_model.sv ----
// host side of the serial command link: one frame task
// assumes clk_in is the bench clock; select idles high, serial clock idles low
`timescale 1ns/10ps
module host_serial_model
(
    // bench clock
    input  wire logic   clk_in,
    // serial pins
    output logic        sclk_out,
    output logic        sel_n_out,
    output logic        mosi_out,
    input  wire logic   miso_in,
    input  wire logic   miso_oe_in,
    // read result, one-cycle strobe
    output logic        rd_done_out,
    output logic [15:0] rd_data_out
);
    initial
    begin
        {sclk_out, mosi_out, rd_done_out, rd_data_out} = '0;
        sel_n_out = 1'b1;
    end

    // five cycles per half bit: the device wants at least four
    task automatic frame(input logic [7:0] cmd, input logic [15:0] data);
        logic [23:0] sh;
        logic        seen;
        sh = {cmd, data};
        seen = 1'b0;
        @(posedge clk_in) #1 sel_n_out = 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            mosi_out = sh[i];
            repeat (5) @(posedge clk_in);
            #1 sclk_out = 1'b1;
            // a released data line is not trusted to hold its last bit
            seen = miso_oe_in ? miso_in : ~seen;
            if (i < 16) rd_data_out[i] = seen;
            repeat (5) @(posedge clk_in);
            #1 sclk_out = 1'b0;
        end
        mosi_out = ~mosi_out;
        repeat (5) @(posedge clk_in);
        #1 sel_n_out = 1'b1;
        rd_done_out = cmd[7];
        @(posedge clk_in) #1 rd_done_out = 1'b0;
        repeat (5) @(posedge clk_in);
    endtask
endmodule

// ---- bench/bias_cfg_regs_bench.sv ----
// self-checking bench: register access over the serial link, adc events, starts
// assumes host_serial_model drives the link; ce_in is held high throughout
`timescale 1ns/10ps
module bias_cfg_regs_bench;
    logic        clk_in = 1'b0;
    logic        nrst_in = 1'b0;
    logic        pin_n = 1'b1;
    logic        conv_wr = 1'b0;
    logic        adc_vld = 1'b0;
    logic        sclk, sel_n, mosi, miso, miso_oe, rd_done;
    logic        conv_start, per_ch, fifo_push, alarm;
    logic [15:0] rd_data, wdata;
    logic [95:0] thr;
    logic [10:0] hw_cfg;
    logic [11:0] sw_cfg;
    logic [15:0] expect_q[$];
    logic [7:0]  codes[10] = '{8'h24, 8'h26, 8'h28, 8'h2A, 8'h30, 8'h32, 8'h34, 8'h36,
                               8'h38, 8'h3A};
    int          mismatches = 0;
    int          comparisons = 0;
    int          cycles = 0;

    always #20 clk_in = ~clk_in;

    host_serial_model host
    (
        .clk_in(clk_in), .sclk_out(sclk), .sel_n_out(sel_n), .mosi_out(mosi),
        .miso_in(miso), .miso_oe_in(miso_oe), .rd_done_out(rd_done), .rd_data_out(rd_data)
    );

    bias_cfg_regs dut
    (
        .clk_in(clk_in), .nrst_in(nrst_in), .ce_in(1'b1),
        .serial_clock_in(sclk), .serial_select_n_in(sel_n), .serial_data_in(mosi),
        .serial_data_out(miso), .serial_data_oe_out(miso_oe),
        .conversion_start_pin_n_in(pin_n), .conversion_write_in(conv_wr),
        .conversion_start_out(conv_start), .conversion_per_channel_out(per_ch),
        .adc_result_valid_in(adc_vld), .fifo_push_out(fifo_push), .alarm_check_out(alarm),
        .thresholds_out(thr), .hw_config_out(hw_cfg), .sw_config_out(sw_cfg)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        comparisons++;
        if (seen !== want)
        begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    // an empty queue yields a value no result can carry
    function automatic logic [15:0] pop();
        pop = 16'hFFFF;
        if (expect_q.size() > 0) pop = expect_q.pop_front();
    endfunction

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // inverts the idle level twice, so the start pin gets a low pulse
    task automatic pulse(ref logic s);
        @(posedge clk_in) #1 s = ~s;
        @(posedge clk_in) #1 s = ~s;
        repeat (8) @(posedge clk_in);
    endtask

    always @(posedge clk_in)
    begin
        cycles++;
        if (rd_done) check(rd_data, pop());
        if (alarm | fifo_push) check({14'h0, fifo_push, alarm}, pop());
        if (conv_start | per_ch) check({14'h0, per_ch, conv_start}, pop());
        if (cycles == 40000)
        begin
            mismatches++;
            test_done();
        end
    end

    initial
    begin
        wdata = 16'($urandom(32'hC3F7));
        for (int p = 0; p < 2; p++)
        begin
            #1 nrst_in = 1'b0;
            repeat (2) @(posedge clk_in);
            #1 nrst_in = 1'b1;
            repeat (4) @(posedge clk_in);
            for (int i = 0; i < 10; i++)
            begin
                expect_q.push_back((i < 8 && i % 2 == 0) ? 16'h0FFF : 16'h0000);
                host.frame(codes[i] | 8'h80, 16'h0000);
            end
            for (int i = 0; i < 10 && p == 0; i++)
            begin
                wdata = 16'($urandom);
                if (i == 8 && wdata[5:4] == 2'h2) wdata[4] = 1'b1;
                expect_q.push_back(wdata & 16'h0FFF);
                host.frame(codes[i], wdata);
                if (i < 8) check({4'h0, thr[i*12 +: 12]}, wdata & 16'h0FFF);
                else if (i == 8) check({5'h00, hw_cfg}, {5'h00, wdata[11:8], wdata[6:0]});
                else check({4'h0, sw_cfg}, wdata & 16'h0FFF);
                host.frame(codes[i] | 8'h80, 16'h0000);
            end
        end
        expect_q.push_back(16'h0000);
        host.frame(8'hC0, 16'h0000);
        for (int m = 0; m < 2; m++)
        begin
            host.frame(8'h38, {9'h000, m[0], 6'h00});
            expect_q.push_back({14'h0, m[0], 1'b1});
            pulse(adc_vld);
            expect_q.push_back(16'h0001);
            pulse(conv_wr);
        end
        for (int k = 1; k < 4; k++)
        begin
            host.frame(8'h38, {10'h000, 2'(k), 4'h0});
            repeat (5)
            begin
                if (k != 2) expect_q.push_back({14'h0, k == 3, 1'b1});
                pulse(pin_n);
            end
            pulse(conv_wr);
        end
        repeat (20) @(posedge clk_in);
        check(16'(expect_q.size()), 16'h0000);
        test_done();
    end
endmodule
